/* File: core/flash_program_erase_control.sv */
// Flash program/erase control registers, mode sequencing and boot entry
`timescale 1ns/10ps
`default_nettype none

module flash_program_erase_control
	import flash_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [REG_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic write_protect_pin,
	input wire logic mode_pin_high,
	input wire logic mode_pin_low,
	input wire logic array_fault,
	input wire logic boot_load_done,
	input wire logic boot_erase_done,
	input wire logic [31:0] cpu_addr,
	output array_state_t array_state,
	output logic [ALL_BLOCKS-1:0] erase_block,
	output chip_mode_t chip_mode,
	output logic expanded_bus,
	output logic boot_erase_all,
	output logic boot_run,
	output logic overlay_hit,
	output logic [31:0] overlay_addr
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic req;
	logic wr;
	logic wr_ctl;
	logic wr_small;
	logic wr_large;
	logic wr_ovl;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wr_ctl = wr && (wb_adr_i == OFS_MODE_CTL);
	assign wr_small = wr && (wb_adr_i == OFS_ESEL_SMALL);
	assign wr_large = wr && (wb_adr_i == OFS_ESEL_LARGE);
	assign wr_ovl = wr && (wb_adr_i == OFS_RAM_OVL);

	// ****************************************
	// Register state
	// ****************************************
	logic [6:0] ctl_q;
	logic [6:0] ctl_d;
	logic [ALL_BLOCKS-1:0] esel_q;
	logic [ALL_BLOCKS-1:0] esel_d;
	logic [3:0] ovl_q;
	logic fault_q;
	logic fault_set;
	logic pin_permit;
	logic both_permit;
	logic captured_q;
	boot_state_t boot_q;

	// Protect pin is active high; the permit bit is its inverse
	assign pin_permit = !write_protect_pin;

	// Error protection only counts while the array is really busy
	assign fault_set = array_fault
		&& (array_state == ST_ERASE || array_state == ST_PROG);

	// ****************************************
	// Mode control next value
	// ****************************************
	always_comb
	begin
		ctl_d = ctl_q;
		if (wr_ctl)
		begin
			ctl_d = wb_dat_i[6:0];
		end
		both_permit = ctl_d[BIT_SOFT_WP] && pin_permit;
		if (!ctl_d[BIT_SOFT_WP])
		begin
			ctl_d[5:0] = 6'h00;
		end
		if (!both_permit)
		begin
			// Setup and verify bits cannot stick without both permits
			ctl_d[BIT_ERASE_PREP] = 1'b0;
			ctl_d[BIT_PROG_PREP] = 1'b0;
			ctl_d[BIT_ERASE_CHK] = 1'b0;
			ctl_d[BIT_PROG_CHK] = 1'b0;
		end
		if (!ctl_d[BIT_ERASE_PREP] || ovl_q[BIT_OVL_SEL])
		begin
			ctl_d[BIT_ERASE_GO] = 1'b0;
		end
		if (!ctl_d[BIT_PROG_PREP] || ovl_q[BIT_OVL_SEL])
		begin
			ctl_d[BIT_PROG_GO] = 1'b0;
		end
		if (fault_set)
		begin
			// Error protection aborts the running operation
			ctl_d[BIT_ERASE_GO] = 1'b0;
			ctl_d[BIT_PROG_GO] = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ctl_q <= CTL_RESET;
		else
			ctl_q <= ctl_d;
	end

	// ****************************************
	// Erase block selection
	// ****************************************
	always_comb
	begin
		esel_d = esel_q;
		if (wr_small)
		begin
			esel_d[SMALL_BLOCKS-1:0] = wb_dat_i[SMALL_BLOCKS-1:0];
		end
		if (wr_large)
		begin
			// Upper nibble is not stored, so it reads back as zero
			esel_d[ALL_BLOCKS-1:SMALL_BLOCKS] =
				wb_dat_i[LARGE_BLOCKS-1:0];
		end
		if ($countones(esel_d) > 1)
		begin
			esel_d = ESEL_RESET;
		end
		if (write_protect_pin)
		begin
			esel_d = ESEL_RESET;
		end
		if (!ctl_d[BIT_SOFT_WP])
		begin
			esel_d = ESEL_RESET;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			esel_q <= ESEL_RESET;
		else
			esel_q <= esel_d;
	end

	// Bit i drives block i, small blocks first in address order
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			erase_block <= ESEL_RESET;
		else
			erase_block <= esel_d;
	end

	// ****************************************
	// Overlay control
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ovl_q <= OVL_RESET;
		else if (wr_ovl)
			ovl_q <= wb_dat_i[3:0];
	end

	// Registered decode: an access right after a write sees old mapping
	overlay_map u_overlay_map (
		.clk(clk),
		.rst_n(rst_n),
		.enable(ovl_q[BIT_OVL_SEL]),
		.area(ovl_q[2:0]),
		.addr(cpu_addr),
		.hit_q(overlay_hit),
		.ram_addr_q(overlay_addr)
	);

	// ****************************************
	// Fault flag
	// ****************************************
	// Sticky until reset; nothing in software clears it
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			fault_q <= 1'b0;
		else if (fault_set)
			fault_q <= 1'b1;
	end

	// ****************************************
	// Array state
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			array_state <= ST_IDLE;
		else if (ctl_d[BIT_ERASE_GO])
			array_state <= ST_ERASE;
		else if (ctl_d[BIT_PROG_GO])
			array_state <= ST_PROG;
		else if (ctl_d[BIT_ERASE_CHK])
			array_state <= ST_ERASE_VERIFY;
		else if (ctl_d[BIT_PROG_CHK])
			array_state <= ST_PROG_VERIFY;
		else if (ctl_d[BIT_ERASE_PREP])
			array_state <= ST_ERASE_SETUP;
		else if (ctl_d[BIT_PROG_PREP])
			array_state <= ST_PROG_SETUP;
		else
			array_state <= ST_IDLE;
	end

	// ****************************************
	// Chip mode capture
	// ****************************************
	// Pins are sampled on the first edge after reset is released
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			captured_q <= 1'b0;
			chip_mode <= CM_USER;
			expanded_bus <= 1'b0;
		end
		else if (!captured_q)
		begin
			captured_q <= 1'b1;
			expanded_bus <= !mode_pin_low;
			if (write_protect_pin)
			begin
				chip_mode <= CM_USER;
			end
			else if (!mode_pin_high)
			begin
				chip_mode <= CM_BOOT;
			end
			else
			begin
				chip_mode <= CM_USER_PROG;
			end
		end
	end

	// ****************************************
	// Boot sequence
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			boot_q <= BT_OFF;
		else
		begin
			unique case (boot_q)
				BT_OFF:
					if (captured_q && chip_mode == CM_BOOT)
						boot_q <= BT_LOAD;
				BT_LOAD:
					if (boot_load_done)
						boot_q <= BT_ERASE;
				BT_ERASE:
					if (boot_erase_done)
						boot_q <= BT_RUN;
				BT_RUN: boot_q <= BT_RUN;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			boot_erase_all <= 1'b0;
			boot_run <= 1'b0;
		end
		else
		begin
			// Whole-array erase must finish before the loaded code runs
			boot_erase_all <= (boot_q == BT_LOAD && boot_load_done)
				|| (boot_q == BT_ERASE && !boot_erase_done);
			boot_run <= (boot_q == BT_ERASE && boot_erase_done)
				|| boot_q == BT_RUN;
		end
	end

	// ****************************************
	// Bus answer
	// ****************************************
	// Every access, mapped or not, is acknowledged one cycle later
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wb_dat_o <= 32'h0000_0000;
		end
		else if (req && !wb_we_i)
		begin
			wb_dat_o <= 32'h0000_0000;
			unique case (wb_adr_i)
				OFS_MODE_CTL: wb_dat_o[7:0] <= {pin_permit, ctl_q};
				OFS_ERR_STAT: wb_dat_o[BIT_FAULT] <= fault_q;
				OFS_ESEL_SMALL: wb_dat_o[7:0] <= esel_q[SMALL_BLOCKS-1:0];
				OFS_ESEL_LARGE:
					wb_dat_o[3:0] <= esel_q[ALL_BLOCKS-1:SMALL_BLOCKS];
				OFS_RAM_OVL: wb_dat_o[3:0] <= ovl_q;
				OFS_CHIP_MODE: wb_dat_o[7:0] <= {boot_run, boot_erase_all,
					expanded_bus, chip_mode, array_state};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // flash_program_erase_control

`default_nettype wire

/* File: core/overlay_map.sv */
// Overlay address decoder: maps one small flash block onto fixed RAM
`timescale 1ns/10ps
`default_nettype none

module overlay_map
	import flash_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [2:0] area,
	input wire logic [31:0] addr,
	output logic hit_q,
	output logic [31:0] ram_addr_q
);

	logic hit_d;

	// Flash block N covers page N of the bottom 32 kbytes
	assign hit_d = enable && (addr[31:15] == OVL_FLASH_PAGE[19:3])
		&& (addr[14:12] == area);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hit_q <= 1'b0;
			ram_addr_q <= OVL_RAM_BASE;
		end
		else
		begin
			hit_q <= hit_d;
			// RAM stays reachable at its own address as well
			ram_addr_q <= {OVL_RAM_BASE[31:12], addr[11:0]};
		end
	end

endmodule // overlay_map

`default_nettype wire

/* File: include/flash_ctl_pkg.sv */
// Package: register map, field positions, reset values and state types
package flash_ctl_pkg;

	// ****************************************
	// Register byte offsets (one word each)
	// ****************************************
	localparam int REG_AW = 8;
	localparam logic [7:0] OFS_MODE_CTL = 8'h00;
	localparam logic [7:0] OFS_ERR_STAT = 8'h04;
	localparam logic [7:0] OFS_ESEL_SMALL = 8'h08;
	localparam logic [7:0] OFS_ESEL_LARGE = 8'h0C;
	localparam logic [7:0] OFS_RAM_OVL = 8'h10;
	localparam logic [7:0] OFS_CHIP_MODE = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_PIN_WP = 7;
	localparam int BIT_SOFT_WP = 6;
	localparam int BIT_ERASE_PREP = 5;
	localparam int BIT_PROG_PREP = 4;
	localparam int BIT_ERASE_CHK = 3;
	localparam int BIT_PROG_CHK = 2;
	localparam int BIT_ERASE_GO = 1;
	localparam int BIT_PROG_GO = 0;
	localparam int BIT_FAULT = 7;
	localparam int BIT_OVL_SEL = 3;
	localparam int SMALL_BLOCKS = 8;
	localparam int LARGE_BLOCKS = 4;
	localparam int ALL_BLOCKS = SMALL_BLOCKS + LARGE_BLOCKS;

	// ****************************************
	// Reset values and fixed addresses
	// ****************************************
	localparam logic [6:0] CTL_RESET = 7'h00;
	localparam logic [ALL_BLOCKS-1:0] ESEL_RESET = 12'h000;
	localparam logic [3:0] OVL_RESET = 4'h0;
	localparam logic [31:0] OVL_RAM_BASE = 32'hFFFF_D000;
	localparam logic [19:0] OVL_FLASH_PAGE = 20'h0_0000;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE, ST_ERASE_SETUP, ST_PROG_SETUP, ST_ERASE_VERIFY,
		ST_PROG_VERIFY, ST_ERASE, ST_PROG
	} array_state_t;

	typedef enum logic [1:0] {
		CM_USER, CM_BOOT, CM_USER_PROG
	} chip_mode_t;

	typedef enum logic [1:0] {
		BT_OFF, BT_LOAD, BT_ERASE, BT_RUN
	} boot_state_t;

endpackage

/* File: test/flash_array_model.sv */
// Stand-in for the flash array and the boot loader
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
	import flash_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire array_state_t array_state,
	input wire logic boot_erase_all,
	input wire logic fault_cmd,
	input wire logic load_cmd,
	output logic array_fault,
	output logic boot_load_done,
	output logic boot_erase_done
);
	// Whole erase takes several cycles, as a real array would
	logic [2:0] cnt_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= 3'h0;
			boot_erase_done <= 1'b0;
		end
		else
		begin
			cnt_q <= boot_erase_all ? cnt_q + 3'h1 : 3'h0;
			boot_erase_done <= cnt_q == 3'h4;
		end
	end
	always_ff @(posedge clk)
	begin
		array_fault <= rst_n && fault_cmd
			&& array_state inside {ST_ERASE, ST_PROG};
		boot_load_done <= rst_n && load_cmd;
	end
endmodule // flash_array_model
`default_nettype wire

/* File: test/flash_ctl_checker_properties.sv */
// Checker: bus handshake and control-state properties
`timescale 1ns/10ps
`default_nettype none
module flash_ctl_checker
	import flash_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [REG_AW-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic write_protect_pin,
	input wire logic array_fault,
	input wire array_state_t array_state,
	input wire logic [ALL_BLOCKS-1:0] erase_block,
	input wire logic boot_erase_all,
	input wire logic boot_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack missing after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_pin_bit;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
			&& wb_adr_i == OFS_MODE_CTL
			|=> wb_dat_o[BIT_PIN_WP] == !$past(write_protect_pin);
	endproperty
	a_pin_bit: assert property (p_pin_bit)
		else $error("pin permit bit wrong");
	property p_pin_clear;
		write_protect_pin && $past(write_protect_pin) |-> erase_block == '0;
	endproperty
	a_pin_clear: assert property (p_pin_clear)
		else $error("block select kept while protected");
	property p_pin_idle;
		write_protect_pin && $past(write_protect_pin) |-> array_state == ST_IDLE;
	endproperty
	a_pin_idle: assert property (p_pin_idle)
		else $error("array active while protected");
	property p_one_block;
		erase_block != '0 |-> $onehot(erase_block);
	endproperty
	a_one_block: assert property (p_one_block)
		else $error("more than one block selected");
	property p_fault;
		array_fault && array_state inside {ST_ERASE, ST_PROG}
			|=> !(array_state inside {ST_ERASE, ST_PROG});
	endproperty
	a_fault: assert property (p_fault)
		else $error("array active after fault");
	property p_boot;
		$rose(boot_run) |-> $past(boot_erase_all);
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot run without whole erase");
endmodule // flash_ctl_checker
bind flash_program_erase_control flash_ctl_checker u_chk (.clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.write_protect_pin, .array_fault, .array_state, .erase_block,
	.boot_erase_all, .boot_run);
`default_nettype wire

/* File: test/flash_program_erase_control_tb.sv */
// Self-checking bench for the flash program/erase control block
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control_tb
	import flash_ctl_pkg::*;
;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, pin = 0;
	logic mhi = 1, mlo = 0, fault, ld_done, er_done, fcmd = 0, lcmd = 0;
	logic erase_all, run, exp_bus, hit;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000, rdat, q, caddr = 32'h0000_0000;
	logic [31:0] oaddr;
	logic [11:0] blk;
	array_state_t st;
	chip_mode_t cm;
	int error_cnt = 0, n_checks = 0, cycles = 0;
	always #2.5 clk = ~clk;
	flash_program_erase_control DUT (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.write_protect_pin(pin), .mode_pin_high(mhi), .mode_pin_low(mlo),
		.array_fault(fault), .boot_load_done(ld_done),
		.boot_erase_done(er_done), .cpu_addr(caddr), .array_state(st),
		.erase_block(blk), .chip_mode(cm), .expanded_bus(exp_bus),
		.boot_erase_all(erase_all), .boot_run(run), .overlay_hit(hit),
		.overlay_addr(oaddr));
	flash_array_model u_arr (.clk(clk), .rst_n(rst_n), .array_state(st),
		.boot_erase_all(erase_all), .fault_cmd(fcmd), .load_cmd(lcmd),
		.array_fault(fault), .boot_load_done(ld_done),
		.boot_erase_done(er_done));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0; stb <= 0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, string n);
		wb(0, a, 32'h0000_0000);
		chk(n, e, q);
	endtask
	task automatic do_reset(logic h, logic l);
		rst_n <= 0; mhi <= h; mlo <= l;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_guard();
		wb(1, OFS_MODE_CTL, 32'h0000_003F);
		rd(OFS_MODE_CTL, 32'h0000_0080, "ctl no soft");
		wb(1, OFS_ESEL_SMALL, 32'h0000_0001);
		rd(OFS_ESEL_SMALL, 32'h0000_0000, "sel no soft");
		rd(OFS_ERR_STAT, 32'h0000_0000, "fault reset");
		rd(8'h40, 32'h0000_0000, "unmapped");
		$display("test guard done");
	endtask
	task automatic t_seq();
		logic [7:0] wv[10] = '{8'h40, 8'h60, 8'h62, 8'h40, 8'h50,
			8'h51, 8'h48, 8'h44, 8'h42, 8'h40};
		array_state_t sv[10] = '{ST_IDLE, ST_ERASE_SETUP, ST_ERASE,
			ST_IDLE, ST_PROG_SETUP, ST_PROG, ST_ERASE_VERIFY,
			ST_PROG_VERIFY, ST_IDLE, ST_IDLE};
		for (int i = 0; i < 10; i++)
		begin
			wb(1, OFS_MODE_CTL, {24'h0, wv[i]});
			chk("state", {29'h0, sv[i]}, {29'h0, st});
			rd(OFS_MODE_CTL, {24'h0, (i == 8) ? 8'hC0 : wv[i] | 8'h80},
				"ctl");
		end
		$display("test sequence done");
	endtask
	task automatic t_blocks();
		wb(1, OFS_ESEL_SMALL, 32'h0000_0004);
		chk("blk small", 32'h0000_0004, {20'h0, blk});
		wb(1, OFS_ESEL_LARGE, 32'h0000_0001);
		chk("blk multi", 32'h0000_0000, {20'h0, blk});
		wb(1, OFS_ESEL_LARGE, 32'h0000_0002);
		chk("blk large", 32'h0000_0200, {20'h0, blk});
		rd(OFS_ESEL_LARGE, 32'h0000_0002, "large rb");
		@(posedge clk) pin <= 1;
		repeat (2) @(posedge clk);
		chk("blk pin", 32'h0000_0000, {20'h0, blk});
		rd(OFS_MODE_CTL, 32'h0000_0040, "pin bit");
		wb(1, OFS_MODE_CTL, 32'h0000_0060);
		rd(OFS_MODE_CTL, 32'h0000_0040, "pin prep");
		@(posedge clk) pin <= 0;
		$display("test blocks done");
	endtask
	task automatic t_overlay();
		wb(1, OFS_RAM_OVL, 32'h0000_000B);
		@(posedge clk) caddr <= 32'h0000_3004;
		repeat (3) @(posedge clk);
		chk("ovl hit", 32'h0000_0001, {31'h0, hit});
		chk("ovl addr", 32'hFFFF_D004, oaddr);
		wb(1, OFS_MODE_CTL, 32'h0000_0050);
		wb(1, OFS_MODE_CTL, 32'h0000_0051);
		chk("ovl go", {29'h0, ST_PROG_SETUP}, {29'h0, st});
		wb(1, OFS_RAM_OVL, 32'h0000_0000);
		$display("test overlay done");
	endtask
	task automatic t_fault();
		wb(1, OFS_MODE_CTL, 32'h0000_0051);
		caddr <= 32'h0000_0080;
		@(posedge clk) fcmd <= 1;
		repeat (3) @(posedge clk);
		fcmd <= 0;
		rd(OFS_ERR_STAT, 32'h0000_0080, "fault flag");
		chk("fault st", {29'h0, ST_PROG_SETUP}, {29'h0, st});
		chk("ovl off", 32'h0000_0000, {31'h0, hit});
		$display("test fault done");
	endtask
	task automatic t_boot();
		do_reset(0, 1);
		chk("boot mode", {30'h0, CM_BOOT}, {30'h0, cm});
		chk("boot bus", 32'h0000_0000, {31'h0, exp_bus});
		@(posedge clk) lcmd <= 1;
		@(posedge clk) lcmd <= 0;
		repeat (2) @(posedge clk);
		chk("boot erase", 32'h0000_0001, {31'h0, erase_all});
		chk("boot wait", 32'h0000_0000, {31'h0, run});
		for (int i = 0; i < 40 && run !== 1'b1; i++)
			@(posedge clk);
		chk("boot run", 32'h0000_0001, {31'h0, run});
		rd(OFS_CHIP_MODE, 32'h0000_0088, "boot status");
		do_reset(1, 0);
		chk("user prog", {30'h0, CM_USER_PROG}, {30'h0, cm});
		chk("exp bus", 32'h0000_0001, {31'h0, exp_bus});
		pin <= 1;
		do_reset(1, 0);
		chk("user mode", {30'h0, CM_USER}, {30'h0, cm});
		pin <= 0;
		$display("test boot done");
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	initial
	begin
		do_reset(1, 0);
		t_guard();
		t_seq();
		t_blocks();
		t_overlay();
		t_fault();
		t_boot();
		finish_test();
	end
endmodule // flash_program_erase_control_tb
`default_nettype wire
